// ### rtl/hpb_port.sv
// hpb_port: device-side slave port for an 8-bit demultiplexed host bus
// assumes: pins synchronous to i_clk_sys; core returns read data each cycle
`timescale 1ns/1ps
module hpb_port (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire hpb_pkg::hpb_pins_t i_pins,
    input wire logic [7:0] i_reg_rdata,
    input wire logic [7:0] i_fifo_rdata,
    output logic [7:0] o_host_data_lines,
    output logic o_host_data_oe,
    output hpb_pkg::hpb_access_t o_access
);

    ////////////////////////////////////////////////////////////////////////
    // strobe decode
    logic rd_act;
    logic wr_act;
    logic sel_reg;
    logic sel_dma;
    logic strobe_on;

    always_comb begin
        // pins are levels sampled on the clock, no edge detect here
        // so a strobe held for many cycles still gives one access
        // strobe polarity
        if (i_pins.strobe_polarity_select == hpb_pkg::POL_ENABLE_HIGH) begin
            strobe_on = i_pins.bus_control_strobe_in;
        end else begin
            strobe_on = ~i_pins.bus_control_strobe_in;
        end
        if (i_pins.bus_style_select == hpb_pkg::STYLE_STROBE) begin
            rd_act = strobe_on & i_pins.bus_direction_in;
            wr_act = strobe_on & ~i_pins.bus_direction_in;
        end else begin
            rd_act = ~i_pins.bus_control_strobe_in;
            wr_act = ~i_pins.bus_direction_in;
        end
        // separate style: read wins if both strobes are low at once
        // chip select low wins over a dma grant seen at the same time
        // chip select gates register access
        sel_reg = ~i_pins.cs_n;
        sel_dma = ~i_pins.dma_grant_n & i_pins.cs_n;
    end

    ////////////////////////////////////////////////////////////////////////
    // access state
    hpb_pkg::hpb_state_t state;
    hpb_pkg::hpb_state_t next_state;
    logic [7:0] dout;
    logic [7:0] next_dout;
    logic oe;
    logic next_oe;
    hpb_pkg::hpb_access_t acc;
    hpb_pkg::hpb_access_t next_acc;

    always_comb begin
        next_state = state;
        next_dout = dout;
        next_oe = 1'b0;
        next_acc = '0;
        // one access per strobe: the machine parks in read or write
        // until the strobe or the select goes away, then idles a cycle
        // access fields are single-cycle pulses, cleared by default
        case (state)
            hpb_pkg::HPB_IDLE: begin
                if ((sel_reg | sel_dma) & rd_act) begin
                    next_state = hpb_pkg::HPB_READ;
                    next_acc.reg_rd = sel_reg;
                    next_acc.fifo_rd = sel_dma;
                    next_acc.index = sel_reg ? i_pins.register_index : hpb_pkg::INDEX_RESET;
                end else if ((sel_reg | sel_dma) & wr_act) begin
                    next_state = hpb_pkg::HPB_WRITE;
                    next_acc.reg_wr = sel_reg;
                    next_acc.fifo_wr = sel_dma;
                    next_acc.index = sel_reg ? i_pins.register_index : hpb_pkg::INDEX_RESET;
                    next_acc.wdata = i_pins.host_data_in;
                end
            end
            hpb_pkg::HPB_READ: begin
                if ((sel_reg | sel_dma) & rd_act) begin
                    next_dout = sel_reg ? i_reg_rdata : i_fifo_rdata;
                    next_oe = 1'b1;
                end else begin
                    next_state = hpb_pkg::HPB_IDLE;
                end
            end
            hpb_pkg::HPB_WRITE: begin
                if (!((sel_reg | sel_dma) & wr_act)) begin
                    next_state = hpb_pkg::HPB_IDLE;
                end
            end
            default: begin
                next_state = hpb_pkg::HPB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state <= hpb_pkg::HPB_IDLE;
            dout <= hpb_pkg::DATA_RESET;
            oe <= 1'b0;
            acc <= '0;
        // clock enable low holds every register, reset still wins
        end else if (i_ce) begin
            state <= next_state;
            dout <= next_dout;
            oe <= next_oe;
            acc <= next_acc;
        end
    end

    // outputs come straight from the registers above
    assign o_host_data_lines = dout;
    assign o_host_data_oe = oe;
    assign o_access = acc;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rd_start;
        state == hpb_pkg::HPB_IDLE && (sel_reg | sel_dma) && rd_act && i_ce;
    endsequence

    oe_no_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        oe |-> $past(state) == hpb_pkg::HPB_READ)
        else $error("data driven without read");
    read_enters_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_rd_start |=> state == hpb_pkg::HPB_READ && acc.reg_rd == $past(sel_reg))
        else $error("read not taken");
    dma_index_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        acc.fifo_rd |-> acc.index == hpb_pkg::INDEX_RESET && !acc.reg_rd)
        else $error("dma read used index");
    reg_wr_cs_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (acc.reg_wr || acc.reg_rd) |-> $past(i_pins.cs_n) == 1'b0)
        else $error("register access without select");
    wr_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        acc.reg_wr |-> acc.wdata == $past(i_pins.host_data_in))
        else $error("write data mismatch");
    fifo_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        acc.fifo_wr |-> !acc.reg_wr && $past(i_pins.dma_grant_n) == 1'b0)
        else $error("fifo push wrong");
    strobe_dir_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_pins.bus_style_select && rd_act) |-> i_pins.bus_direction_in)
        else $error("direction ignored");
    strobe_pol_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_pins.bus_style_select && (rd_act || wr_act)) |->
            i_pins.bus_control_strobe_in != i_pins.strobe_polarity_select)
        else $error("strobe polarity wrong");
    oe_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (oe && $past(sel_reg) && $past(i_ce)) |-> dout == $past(i_reg_rdata))
        else $error("read data mismatch");

    ////////////////////////////////////////////////////////////////////////
    // further checks
    // write taken from idle, read wins a tie
    sequence s_wr_start;
        state == hpb_pkg::HPB_IDLE && (sel_reg | sel_dma) && wr_act && !rd_act && i_ce;
    endsequence

    // read strobe still held with a select
    sequence s_rd_hold;
        state == hpb_pkg::HPB_READ && (sel_reg | sel_dma) && rd_act && i_ce;
    endsequence

    // read strobe gone or select lost
    sequence s_rd_end;
        state == hpb_pkg::HPB_READ && !((sel_reg | sel_dma) && rd_act) && i_ce;
    endsequence

    // nothing selected while running
    sequence s_unselected;
        state == hpb_pkg::HPB_IDLE && !(sel_reg | sel_dma) && i_ce;
    endsequence

    wr_enters_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_wr_start |=> state == hpb_pkg::HPB_WRITE && acc.fifo_wr == $past(sel_dma))
        else $error("write not taken");
    rd_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_rd_hold |=> oe)
        else $error("read not driven");
    oe_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_rd_end |=> !oe && state == hpb_pkg::HPB_IDLE)
        else $error("drivers left on");
    idle_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        s_unselected |=> acc == '0 && state == hpb_pkg::HPB_IDLE)
        else $error("access without select");
    dma_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (oe && $past(sel_dma) && $past(i_ce)) |-> dout == $past(i_fifo_rdata))
        else $error("fifo data mismatch");
    pulse_once_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (acc.reg_wr && i_ce) |=> !acc.reg_wr)
        else $error("write pulse too long");
    fifo_cs_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (acc.fifo_wr || acc.fifo_rd) |-> $past(i_pins.cs_n) == 1'b1)
        else $error("fifo access with select");
    sep_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (state == hpb_pkg::HPB_IDLE && !i_pins.bus_style_select && !i_pins.cs_n
            && !i_pins.bus_control_strobe_in && i_ce)
            |=> acc.reg_rd && acc.index == $past(i_pins.register_index))
        else $error("separate read not taken");
    // frozen registers must not move while the enable is low
    ce_freeze_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_ce |=> $stable(state) && $stable(oe) && $stable(dout) && $stable(acc))
        else $error("state moved while frozen");
endmodule

// ### rtl/hpb_pkg.sv
// hpb_pkg: shared constants and carrier types for the host parallel bus port
// assumes: 8-bit data bus, 7-bit register index
package hpb_pkg;
    localparam int DATA_W = 8;
    localparam int INDEX_W = 7;
    localparam logic STYLE_SEPARATE = 1'b0;
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic POL_ENABLE_HIGH = 1'b0;
    localparam logic POL_STROBE_LOW = 1'b1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] INDEX_RESET = 7'h00;

    // pin group as seen from the host bus
    typedef struct packed {
        logic cs_n;
        logic dma_grant_n;
        logic bus_control_strobe_in;
        logic bus_direction_in;
        logic bus_style_select;
        logic strobe_polarity_select;
        logic [INDEX_W-1:0] register_index;
        logic [DATA_W-1:0] host_data_in;
    } hpb_pins_t;

    // one register or fifo access toward the core
    typedef struct packed {
        logic reg_wr;
        logic reg_rd;
        logic fifo_wr;
        logic fifo_rd;
        logic [INDEX_W-1:0] index;
        logic [DATA_W-1:0] wdata;
    } hpb_access_t;

    typedef enum logic [1:0] {
        HPB_IDLE = 2'b00,
        HPB_READ = 2'b01,
        HPB_WRITE = 2'b10
    } hpb_state_t;
endpackage

// ### sim/hpb_host.sv
// hpb_host: host bus master model that drives the port pin group
// assumes: the port samples its pins on rising edges of i_clk_sys
`timescale 1ns/1ps
module hpb_host (
    input wire logic i_clk_sys,
    output hpb_pkg::hpb_pins_t o_pins
);
    initial o_pins = {4'hF, 17'h00000};
    task automatic xfer(input logic cs, dg, st, pol, rd, input logic [6:0] idx,
        input logic [7:0] d);
        logic act;
        act = st & ~pol;
        @(posedge i_clk_sys);
        o_pins <= {cs, dg, st ? act : ~rd, rd, st, pol, idx, rd ? ~d : d};
        repeat (4) @(posedge i_clk_sys);
        // released data lines show the inverse
        o_pins <= {2'b11, st ? ~act : 1'b1, 1'b1, st, pol, idx, ~d};
        repeat (3) @(posedge i_clk_sys);
    endtask
endmodule

// ### sim/testbench.sv
// testbench: scenario bench for the host parallel bus port
// assumes: hpb_host drives the pins, a small core model answers reads
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [6:0] idx_q = 7'h00;
    logic [7:0] fifo_rdata = 8'h3C;
    logic [7:0] rd_seen;
    logic [7:0] data;
    logic oe;
    int bad_count = 0;
    int compares = 0;
    int pulses;
    int oe_n;
    int cyc = 0;
    hpb_pkg::hpb_pins_t pins;
    hpb_pkg::hpb_access_t acc, acc_seen;
    wire logic [7:0] reg_rdata = {1'b1, acc.reg_rd ? acc.index : idx_q};
    hpb_host host (.i_clk_sys(clk), .o_pins(pins));
    hpb_port dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_pins(pins),
        .i_reg_rdata(reg_rdata), .i_fifo_rdata(fifo_rdata),
        .o_host_data_lines(data), .o_host_data_oe(oe), .o_access(acc));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (acc.reg_rd === 1'b1) idx_q <= acc.index;
        if (acc[18:15] !== 4'h0) begin
            pulses++;
            acc_seen = acc;
        end
        if (oe === 1'b1) begin
            oe_n++;
            rd_seen = data;
        end
        if (cyc == 2000) begin
            bad_count++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic txn(input logic cs, dg, st, pol, rd, input logic [6:0] idx,
        input logic [7:0] d, input logic [3:0] kind, input logic [7:0] er);
        pulses = 0;
        oe_n = 0;
        rd_seen = ~er;
        host.xfer(cs, dg, st, pol, rd, idx, d);
        chk(pulses, kind != 4'h0);
        chk(oe, 1'b0);
        if (kind != 4'h0) chk(acc_seen[18:15], kind);
        if (kind[3]) chk(acc_seen[14:0], {idx, d});
        if (kind[1]) chk(acc_seen[7:0], d);
        if (rd & kind != 4'h0) chk(rd_seen, er);
        if (!rd | kind == 4'h0) chk(oe_n, 0);
    endtask
    task t_reg_rd; txn(0, 1, 0, 0, 1, 7'h55, 8'h00, 4'h4, 8'hD5); endtask
    task t_reg_wr; txn(0, 1, 0, 0, 0, 7'h2A, 8'hC3, 4'h8, 8'h00); endtask
    task t_dma_rd; txn(1, 0, 0, 0, 1, 7'h33, 8'h00, 4'h1, 8'h3C); endtask
    task t_dma_wr; txn(1, 0, 0, 0, 0, 7'h11, 8'h96, 4'h2, 8'h00); endtask
    task t_en_hi; txn(0, 1, 1, 0, 1, 7'h0F, 8'h00, 4'h4, 8'h8F); endtask
    task t_en_wr; txn(0, 1, 1, 0, 0, 7'h40, 8'h5A, 4'h8, 8'h00); endtask
    task t_ds_lo; txn(0, 1, 1, 1, 1, 7'h01, 8'h00, 4'h4, 8'h81); endtask
    task t_ds_wr; txn(0, 1, 1, 1, 0, 7'h7F, 8'hE1, 4'h8, 8'h00); endtask
    task t_none; txn(1, 1, 0, 0, 1, 7'h22, 8'h00, 4'h0, 8'h00); endtask
    task t_cs_win; txn(0, 0, 0, 0, 0, 7'h3E, 8'h7C, 4'h8, 8'h00); endtask
    task t_ce_off;
        ce <= 1'b0;
        txn(0, 1, 0, 0, 0, 7'h12, 8'hA5, 4'h0, 8'h00);
        ce <= 1'b1;
    endtask
    task finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(oe, 1'b0);
        t_reg_rd;
        t_reg_wr;
        t_dma_rd;
        // fifo read reports index zero
        chk(acc_seen[14:8], 7'h00);
        t_dma_wr;
        t_en_hi;
        t_en_wr;
        t_ds_lo;
        t_ds_wr;
        t_none;
        t_cs_win;
        t_ce_off;
        finish_test;
    end
endmodule
